/* File: bspm_boot_strap_pin_mux.sv */
`include "bspm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Kickstart is the go command; normal operation starts only on it.
// - Autoboot strap is captured at reset release to choose loading.
// - Strap low in I2C or SPI mode: device reads its code over the 8-bit memory bus.
// - When running, the strap pin is an open-drain message request.
// - Parallel host modes put the host interface on the twelve pins.
// - Serial host modes put the external memory interface on the pins.
// - Serial modes may give the pins to the application instead.
// - External memory is never available in a parallel host mode.
// - Bypass strap low selects PLL clock; high selects direct clock.
// - Without a valid host mode strap the pins leave reset as floating inputs.
// - Strap levels at reset release fix the host mode.
// - In I2C mode the serial data line is driven open drain.
// - Strobes 111 par A, 110 par B, 01x I2C, 10x SPI.
module bspm_boot_strap_pin_mux
  import bspm_pkg::*;
#(
  parameter int GPIO_WIDTH = `BSPM_GPIO_WIDTH,
  parameter int EMEM_WIDTH = `BSPM_EMEM_WIDTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic strap_read_n,
  input wire logic strap_write_n,
  input wire logic strap_parallel_sel,
  input wire logic autoboot_strap,
  input wire logic pll_bypass_select,
  input wire logic pll_clock,
  input wire logic direct_ref_clock_input,
  output logic dsp_clock_sel_direct,
  output logic dsp_clock,
  input wire logic autoboot_done,
  input wire logic download_done,
  input wire logic hw_config_done,
  input wire logic kickstart,
  output logic running,
  output logic load_by_host,
  output logic autoboot_active,
  output bspm_mode_t host_mode,
  output bspm_gpio_role_t gpio_role,
  input wire logic app_gpio_enable,
  input wire logic message_pending,
  output logic host_message_request_n_out,
  output logic host_message_request_n_oe,
  input wire logic [EMEM_WIDTH-1:0] emem_addr_data_out,
  input wire logic emem_addr_data_drive,
  output logic [EMEM_WIDTH-1:0] emem_addr_data_in,
  input wire logic [GPIO_WIDTH-1:0] host_if_out,
  input wire logic [GPIO_WIDTH-1:0] host_if_oe,
  output logic [GPIO_WIDTH-1:0] host_if_in,
  input wire logic [GPIO_WIDTH-1:0] app_gpio_out,
  input wire logic [GPIO_WIDTH-1:0] app_gpio_oe,
  output logic [GPIO_WIDTH-1:0] app_gpio_in,
  input wire logic [GPIO_WIDTH-1:0] gpio_in,
  output logic [GPIO_WIDTH-1:0] gpio_out,
  output logic [GPIO_WIDTH-1:0] gpio_oe,
  input wire logic i2c_data_pull_low,
  output logic serial_data_line_out,
  output logic serial_data_line_oe
);
  bspm_state_t state;
  bspm_state_t next_state;
  bspm_mode_t next_host_mode;
  logic captured;
  logic next_captured;
  logic load_host;
  logic next_load_host;
  logic clk_direct;
  logic next_clk_direct;
  logic [GPIO_WIDTH-1:0] next_gpio_out;
  logic [GPIO_WIDTH-1:0] next_gpio_oe;
  logic [EMEM_WIDTH-1:0] next_emem_in;
  logic [GPIO_WIDTH-1:0] next_host_in;
  logic [GPIO_WIDTH-1:0] next_app_in;
  logic serial_mode;

  // Straps are caught on the first clock after reset is released.
  always_comb begin
    next_captured = 1'b1;
    next_host_mode = host_mode;
    next_load_host = load_host;
    next_clk_direct = clk_direct;
    if (!captured) begin
      next_clk_direct = pll_bypass_select;
      unique case ({strap_read_n, strap_write_n})
        `BSPM_STRAP_PARALLEL: next_host_mode = strap_parallel_sel ?
            bspm_mode_par_a : bspm_mode_par_b;
        `BSPM_STRAP_I2C: next_host_mode = bspm_mode_i2c;
        `BSPM_STRAP_SPI: next_host_mode = bspm_mode_spi;
        default: next_host_mode = bspm_mode_none;
      endcase
      // Autoboot needs the memory pins, so only serial modes may take it.
      next_load_host = autoboot_strap ||
          !(next_host_mode inside {bspm_mode_i2c, bspm_mode_spi});
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      captured <= 1'b0;
      host_mode <= bspm_mode_none;
      load_host <= 1'b1;
      clk_direct <= 1'b0;
    end else begin
      captured <= next_captured;
      host_mode <= next_host_mode;
      load_host <= next_load_host;
      clk_direct <= next_clk_direct;
    end
  end

  assign serial_mode = (host_mode == bspm_mode_i2c) ||
                       (host_mode == bspm_mode_spi);

  // Autoboot is honoured only in serial modes since memory needs the pins.
  always_comb begin
    next_state = state;
    unique case (state)
      bspm_st_boot_wait: begin
        if (captured) begin
          if (!load_host && serial_mode) begin
            next_state = bspm_st_autoboot;
          end else if (download_done) begin
            next_state = bspm_st_config;
          end
        end
      end
      bspm_st_autoboot: begin
        if (autoboot_done) begin
          next_state = bspm_st_config;
        end
      end
      bspm_st_config: begin
        if (hw_config_done && kickstart) begin
          next_state = bspm_st_run;
        end
      end
      bspm_st_run: begin
        next_state = bspm_st_run;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= bspm_st_boot_wait;
    end else begin
      state <= next_state;
    end
  end

  assign running = (state == bspm_st_run);
  assign load_by_host = load_host;
  assign autoboot_active = (state == bspm_st_autoboot);
  assign dsp_clock_sel_direct = clk_direct;
  assign dsp_clock = clk_direct ? direct_ref_clock_input : pll_clock;

  // Pin role: host bus in parallel modes, memory or application in serial.
  always_comb begin
    gpio_role = bspm_gpio_input;
    if (captured) begin
      unique case (host_mode)
        bspm_mode_par_a, bspm_mode_par_b: gpio_role = bspm_gpio_host;
        bspm_mode_i2c, bspm_mode_spi: begin
          if (state == bspm_st_run && app_gpio_enable) begin
            gpio_role = bspm_gpio_app;
          end else begin
            gpio_role = bspm_gpio_emem;
          end
        end
        bspm_mode_none: gpio_role = bspm_gpio_input;
      endcase
    end
  end

  always_comb begin
    next_gpio_out = '0;
    next_gpio_oe = `BSPM_GPIO_RESET_OE;
    next_emem_in = '0;
    next_host_in = '0;
    next_app_in = '0;
    unique case (gpio_role)
      bspm_gpio_host: begin
        next_gpio_out = host_if_out;
        next_gpio_oe = host_if_oe;
        next_host_in = gpio_in;
      end
      bspm_gpio_emem: begin
        // Memory bus only reachable here, never in parallel modes.
        next_gpio_out[EMEM_WIDTH-1:0] = emem_addr_data_out;
        next_gpio_oe[EMEM_WIDTH-1:0] = {EMEM_WIDTH{emem_addr_data_drive}};
        next_emem_in = gpio_in[EMEM_WIDTH-1:0];
      end
      bspm_gpio_app: begin
        next_gpio_out = app_gpio_out;
        next_gpio_oe = app_gpio_oe;
        next_app_in = gpio_in;
      end
      bspm_gpio_input: begin
        next_gpio_oe = `BSPM_GPIO_RESET_OE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gpio_out <= '0;
      gpio_oe <= `BSPM_GPIO_RESET_OE;
      emem_addr_data_in <= '0;
      host_if_in <= '0;
      app_gpio_in <= '0;
    end else begin
      gpio_out <= next_gpio_out;
      gpio_oe <= next_gpio_oe;
      emem_addr_data_in <= next_emem_in;
      host_if_in <= next_host_in;
      app_gpio_in <= next_app_in;
    end
  end

  // The strap pin turns into the message request only once running.
  bspm_od_pin u_msg_req (
    .pull_low(running && message_pending),
    .pin_out(host_message_request_n_out),
    .pin_oe(host_message_request_n_oe)
  );

  bspm_od_pin u_sda (
    .pull_low((host_mode == bspm_mode_i2c) && i2c_data_pull_low),
    .pin_out(serial_data_line_out),
    .pin_oe(serial_data_line_oe)
  );
endmodule
`default_nettype wire

/* File: bspm_defs.svh */
`ifndef BSPM_DEFS_SVH
`define BSPM_DEFS_SVH
// Host mode strap encodings: {read strobe, write strobe}.
`define BSPM_STRAP_PARALLEL 2'b11
`define BSPM_STRAP_I2C 2'b01
`define BSPM_STRAP_SPI 2'b10
`define BSPM_GPIO_WIDTH 12
`define BSPM_EMEM_WIDTH 8
`define BSPM_GPIO_RESET_OE 12'h000
`endif

/* File: bspm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bspm_host_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic load_by_host,
  input wire logic [3:0] gap,
  output logic download_done,
  output logic hw_config_done,
  output logic kickstart
);
  logic [5:0] cnt;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 6'h00;
    end else if (cnt != 6'h3F) begin
      cnt <= cnt + 6'h01;
    end
  end
  // The host loads only when load_by_host is set, then configures, then gives the go command.
  assign download_done = load_by_host && cnt > {2'h0, gap};
  assign hw_config_done = cnt > 6'h02 + {1'b0, gap, 1'b0};
  assign kickstart = cnt > 6'h04 + {1'b0, gap, 1'b0} + {2'h0, gap};
endmodule
`default_nettype wire

/* File: bspm_od_pin.sv */
`timescale 1ns/1ps
`default_nettype none
module bspm_od_pin (
  input wire logic pull_low,
  output logic pin_out,
  output logic pin_oe
);
  // The pin is only ever pulled low or released.
  assign pin_out = 1'b0;
  assign pin_oe = pull_low;
endmodule
`default_nettype wire

/* File: bspm_pin_mux_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module bspm_checker
  import bspm_pkg::*;
#(
  parameter int GPIO_WIDTH = 12
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic strap_read_n,
  input wire logic strap_write_n,
  input wire logic strap_parallel_sel,
  input wire logic autoboot_strap,
  input wire logic kickstart,
  input wire logic hw_config_done,
  input wire logic running,
  input wire logic load_by_host,
  input wire bspm_mode_t host_mode,
  input wire bspm_gpio_role_t gpio_role,
  input wire logic message_pending,
  input wire logic i2c_data_pull_low,
  input wire logic host_message_request_n_out,
  input wire logic host_message_request_n_oe,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe,
  input wire logic [GPIO_WIDTH-1:0] gpio_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  bspm_mode_t dec;
  logic ldh;
  logic ser;
  always_comb begin
    if (strap_read_n && strap_write_n) begin
      dec = strap_parallel_sel ? bspm_mode_par_a : bspm_mode_par_b;
    end else if (strap_write_n) begin
      dec = bspm_mode_i2c;
    end else if (strap_read_n) begin
      dec = bspm_mode_spi;
    end else begin
      dec = bspm_mode_none;
    end
  end
  assign ser = host_mode inside {bspm_mode_i2c, bspm_mode_spi};
  assign ldh = autoboot_strap || !(dec inside {bspm_mode_i2c, bspm_mode_spi});
  property p_mode; $fell(rst) |=> host_mode == $past(dec); endproperty
  a_mode: assert property (p_mode) else $error("host mode");
  property p_hold; !$past(rst, 2) |-> $stable(host_mode); endproperty
  a_hold: assert property (p_hold) else $error("mode moved");
  property p_load; $fell(rst) |=> load_by_host == $past(ldh); endproperty
  a_load: assert property (p_load) else $error("load choice");
  property p_kick; $rose(running) |-> $past(kickstart && hw_config_done);
  endproperty
  a_kick: assert property (p_kick) else $error("early run");
  property p_od; !host_message_request_n_out && !serial_data_line_out;
  endproperty
  a_od: assert property (p_od) else $error("drove high");
  property p_req;
    host_message_request_n_oe == (running && message_pending);
  endproperty
  a_req: assert property (p_req) else $error("msg request");
  property p_sda; serial_data_line_oe ==
    (host_mode == bspm_mode_i2c && i2c_data_pull_low); endproperty
  a_sda: assert property (p_sda) else $error("sda");
  property p_emem; gpio_role == bspm_gpio_emem |-> ser; endproperty
  a_emem: assert property (p_emem) else $error("emem role");
  property p_par; !ser && host_mode != bspm_mode_none |->
    gpio_role == bspm_gpio_host; endproperty
  a_par: assert property (p_par) else $error("host role");
  property p_in; gpio_role == bspm_gpio_input |=> gpio_oe == '0; endproperty
  a_in: assert property (p_in) else $error("pins driven");
endmodule
bind bspm_boot_strap_pin_mux bspm_checker #(.GPIO_WIDTH(GPIO_WIDTH)) u_chk (.*);
`default_nettype wire

/* File: bspm_pkg.sv */
package bspm_pkg;
  typedef enum logic [2:0] {
    bspm_mode_par_a,
    bspm_mode_par_b,
    bspm_mode_i2c,
    bspm_mode_spi,
    bspm_mode_none
  } bspm_mode_t;
  typedef enum logic [1:0] {
    bspm_st_boot_wait,
    bspm_st_autoboot,
    bspm_st_config,
    bspm_st_run
  } bspm_state_t;
  typedef enum logic [1:0] {
    bspm_gpio_input,
    bspm_gpio_host,
    bspm_gpio_emem,
    bspm_gpio_app
  } bspm_gpio_role_t;
endpackage

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bspm_pkg::*;
  logic clock = 0, rst = 1, strap_read_n, strap_write_n, strap_parallel_sel;
  logic autoboot_strap, pll_bypass_select, dsp_clock_sel_direct, dsp_clock;
  logic autoboot_done, download_done, hw_config_done, kickstart, running;
  logic load_by_host, autoboot_active, app_gpio_enable, message_pending;
  logic host_message_request_n_out, host_message_request_n_oe;
  logic emem_addr_data_drive, i2c_data_pull_low;
  logic serial_data_line_out, serial_data_line_oe;
  logic [7:0] emem_addr_data_out, emem_addr_data_in;
  logic [11:0] host_if_out, host_if_oe, host_if_in, app_gpio_out;
  logic [11:0] app_gpio_oe, app_gpio_in, gpio_in, gpio_out, gpio_oe;
  logic [3:0] gap;
  bspm_mode_t host_mode;
  bspm_gpio_role_t gpio_role;
  int fails = 0;
  int n_checks = 0;
  wire pll_clock = clock;
  wire direct_ref_clock_input = ~clock;
  bspm_boot_strap_pin_mux bspm_boot_strap_pin_mux_inst (.*);
  bspm_host_model bspm_host_model_inst (.*);
  always #5 clock = ~clock;
  task automatic chk(input string nm, input logic [11:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // Straps are {bypass, read, write, parallel select, autoboot}.
  task automatic boot(input logic [4:0] s, input logic [3:0] g,
                      input bspm_mode_t m, input logic ld);
    @(posedge clock);
    rst <= 1'b1;
    {pll_bypass_select, strap_read_n, strap_write_n} <= s[4:2];
    {strap_parallel_sel, autoboot_strap} <= s[1:0];
    {autoboot_done, app_gpio_enable, emem_addr_data_drive} <= 3'h0;
    gap <= g;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk("host_mode", 12'(m), 12'(host_mode));
    chk("load_by_host", 12'(ld), 12'(load_by_host));
    chk("clock_sel", 12'(s[4]), 12'(dsp_clock_sel_direct));
    chk("dsp_clock", 12'(!s[4]), 12'(dsp_clock));
  endtask
  task automatic wait_run;
    for (int i = 0; i < 40 && running !== 1'b1; i++) @(posedge clock);
    #1;
    chk("running", 12'h001, 12'(running));
    chk("msg_req_oe", 12'h001, 12'(host_message_request_n_oe));
    chk("msg_req_out", 12'h000, 12'(host_message_request_n_out));
  endtask
  task automatic t_parallel;
    boot(5'b01110, 4'h0, bspm_mode_par_a, 1'b1);
    chk("gpio_role", 12'(bspm_gpio_host), 12'(gpio_role));
    chk("gpio_oe", host_if_oe, gpio_oe);
    chk("gpio_out", host_if_out, gpio_out);
    chk("host_if_in", gpio_in, host_if_in);
    wait_run();
    boot(5'b11101, 4'h3, bspm_mode_par_b, 1'b1);
    chk("early_run", 12'h000, 12'(running));
    wait_run();
    $display("parallel test done");
  endtask
  task automatic t_autoboot;
    boot(5'b11000, 4'h0, bspm_mode_spi, 1'b0);
    chk("autoboot_active", 12'h001, 12'(autoboot_active));
    chk("gpio_role", 12'(bspm_gpio_emem), 12'(gpio_role));
    @(posedge clock);
    emem_addr_data_drive <= 1'b1;
    repeat (12) @(posedge clock);
    #1;
    chk("gpio_oe", 12'h0FF, gpio_oe);
    chk("gpio_out", 12'(emem_addr_data_out), 12'(gpio_out[7:0]));
    chk("emem_in", 12'(gpio_in[7:0]), 12'(emem_addr_data_in));
    chk("no_run", 12'h000, 12'(running));
    @(posedge clock);
    autoboot_done <= 1'b1;
    wait_run();
    @(posedge clock);
    app_gpio_enable <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("gpio_role", 12'(bspm_gpio_app), 12'(gpio_role));
    chk("gpio_oe", app_gpio_oe, gpio_oe);
    chk("gpio_out", app_gpio_out, gpio_out);
    chk("app_gpio_in", gpio_in, app_gpio_in);
    $display("autoboot test done");
  endtask
  task automatic t_serial;
    boot(5'b00111, 4'h1, bspm_mode_i2c, 1'b1);
    chk("sda_oe", 12'h001, 12'(serial_data_line_oe));
    chk("sda_out", 12'h000, 12'(serial_data_line_out));
    chk("gpio_oe", 12'h000, gpio_oe);
    wait_run();
    boot(5'b00000, 4'h0, bspm_mode_none, 1'b1);
    chk("gpio_oe", 12'h000, gpio_oe);
    chk("gpio_role", 12'(bspm_gpio_input), 12'(gpio_role));
    $display("serial test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {strap_read_n, strap_write_n, strap_parallel_sel, autoboot_strap} = 4'h0;
    {pll_bypass_select, autoboot_done, app_gpio_enable} = 3'h0;
    {emem_addr_data_drive, message_pending, i2c_data_pull_low} = 3'h3;
    {host_if_out, host_if_oe, app_gpio_out} = {12'h3C6, 12'hA5C, 12'h5A3};
    {app_gpio_oe, gpio_in, emem_addr_data_out} = {12'h9C1, 12'h6B2, 8'h5A};
    gap = 4'h0;
    t_parallel();
    t_autoboot();
    t_serial();
    report_and_stop();
  end
  initial begin
    #20000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
